//--- core/pwm_phase_and_duty_config.sv
// Switching rate, interleave phase and duty limit of the digital PWM controller
`timescale 1ns/1ps
`include "pwm_cfg_consts.svh"

module pwm_phase_and_duty_config #(
	parameter int PER_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire pwm_cfg_pkg::reg_access_t cfg,
	input wire logic rd_sel,
	output logic [7:0] rd_data,
	input wire logic sync_line,
	input wire logic converter_enable,
	input wire logic phase_slot_strap,
	input wire logic [4:0] device_address,
	input wire pwm_cfg_pkg::demand_t demand,
	output logic pwm_out,
	output logic cycle_start
);

	logic [7:0] phase_frequency_config_reg;
	logic [7:0] duty_saturation_config_reg;
	logic slot_loaded_reg;
	logic sync_prev_reg;
	logic sync_edge;
	logic [PER_W-1:0] period_reg;
	logic [PER_W-1:0] period_next;
	logic [PER_W-1:0] phase_cycles;
	logic [PER_W-1:0] limit_cycles;
	logic [PER_W-1:0] on_scaled;
	logic [PER_W-1:0] on_cycles_reg;
	logic [PER_W-1:0] delay_cnt_reg;
	logic [PER_W-1:0] cyc_cnt_reg;
	logic [5:0] duty_sel;
	logic [2:0] switch_rate_select;
	logic [4:0] phase_slot;
	logic [5:0] duty_limit;
	logic over_window_saturation_en;
	logic under_window_saturation_en;
	logic start_now;
	logic [7:0] rd_data_reg;
	logic pwm_out_reg;
	logic cycle_start_reg;
	pwm_cfg_pkg::timing_state_t state_reg;
	pwm_cfg_pkg::timing_state_t state_next;

	// Field views
	assign switch_rate_select = phase_frequency_config_reg[`RATE_MSB:`RATE_LSB];
	assign phase_slot = phase_frequency_config_reg[`SLOT_MSB:`SLOT_LSB];
	assign duty_limit = duty_saturation_config_reg[`LIMIT_MSB:`LIMIT_LSB];
	assign over_window_saturation_en = duty_saturation_config_reg[`OVER_EN_BIT];
	assign under_window_saturation_en = duty_saturation_config_reg[`UNDER_EN_BIT];
	assign sync_edge = sync_line & ~sync_prev_reg;
	assign rd_data = rd_data_reg;
	assign pwm_out = pwm_out_reg;
	assign cycle_start = cycle_start_reg;

	// Phase/frequency register, strap load just after reset release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_frequency_config_reg <= `PHASE_FREQ_RESET;
			slot_loaded_reg <= 1'b0;
		end else if (!slot_loaded_reg) begin
			slot_loaded_reg <= 1'b1;
			phase_frequency_config_reg[`SLOT_MSB:`SLOT_LSB] <=
				phase_slot_strap ? device_address : `SLOT_GROUNDED;
		end else if (cfg.wr && cfg.sel == `REG_PHASE_FREQ && !converter_enable) begin
			phase_frequency_config_reg <= cfg.data;
		end
	end

	// Duty/saturation register, writable at any time
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			duty_saturation_config_reg <= `DUTY_SAT_RESET;
		end else if (cfg.wr && cfg.sel == `REG_DUTY_SAT) begin
			duty_saturation_config_reg <= cfg.data;
		end
	end

	// Register read port
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data_reg <= 8'h00;
		end else begin
			rd_data_reg <= (rd_sel == `REG_DUTY_SAT) ? duty_saturation_config_reg
				: phase_frequency_config_reg;
		end
	end

	// Switching period in clock cycles per rate code
	always_comb begin
		case (switch_rate_select)
			3'h0: period_next = PER_W'(`PERIOD_CYCLES(0));
			3'h1: period_next = PER_W'(`PERIOD_CYCLES(1));
			3'h2: period_next = PER_W'(`PERIOD_CYCLES(2));
			3'h3: period_next = PER_W'(`PERIOD_CYCLES(3));
			3'h4: period_next = PER_W'(`PERIOD_CYCLES(4));
			3'h5: period_next = PER_W'(`PERIOD_CYCLES(5));
			3'h6: period_next = PER_W'(`PERIOD_CYCLES(6));
			3'h7: period_next = PER_W'(`PERIOD_CYCLES(7));
			default: period_next = PER_W'(`PERIOD_CYCLES(0));
		endcase
	end

	// Divider period and sync edge memory
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			period_reg <= PER_W'(`PERIOD_CYCLES(0));
			sync_prev_reg <= 1'b0;
		end else begin
			period_reg <= period_next;
			sync_prev_reg <= sync_line;
		end
	end

	// Phase lag and duty limit in cycles
	frac_scale #(.PER_W(PER_W), .FRAC_W(`SLOT_SHIFT)) u_phase_scale (
		.period(period_reg),
		.frac(phase_slot),
		.scaled(phase_cycles)
	);

	frac_scale #(.PER_W(PER_W), .FRAC_W(`DUTY_SHIFT)) u_limit_scale (
		.period(period_reg),
		.frac(duty_limit),
		.scaled(limit_cycles)
	);

	frac_scale #(.PER_W(PER_W), .FRAC_W(`DUTY_SHIFT)) u_on_scale (
		.period(period_reg),
		.frac(duty_sel),
		.scaled(on_scaled)
	);

	// Duty choice: saturation first, else demand clamped to limit
	always_comb begin
		if (demand.over && over_window_saturation_en) begin
			duty_sel = duty_limit;
		end else if (demand.under && under_window_saturation_en) begin
			duty_sel = 6'h00;
		end else if (demand.duty > duty_limit) begin
			duty_sel = duty_limit;
		end else begin
			duty_sel = demand.duty;
		end
	end

	// Sequencer: sync edge -> phase delay -> free-running cycles
	always_comb begin
		state_next = state_reg;
		start_now = 1'b0;
		case (state_reg)
			pwm_cfg_pkg::ST_IDLE: begin
				if (sync_edge) begin
					state_next = pwm_cfg_pkg::ST_DELAY;
				end
			end
			pwm_cfg_pkg::ST_DELAY: begin
				if (delay_cnt_reg == '0) begin
					state_next = pwm_cfg_pkg::ST_RUN;
					start_now = 1'b1;
				end
			end
			pwm_cfg_pkg::ST_RUN: begin
				if (sync_edge) begin
					state_next = pwm_cfg_pkg::ST_DELAY;
				end else if (cyc_cnt_reg == period_reg - PER_W'(1)) begin
					start_now = 1'b1;
				end
			end
			default: state_next = pwm_cfg_pkg::ST_IDLE;
		endcase
		if (!converter_enable) begin
			state_next = pwm_cfg_pkg::ST_IDLE;
			start_now = 1'b0;
		end
	end

	// Sequencer state and counters
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= pwm_cfg_pkg::ST_IDLE;
			delay_cnt_reg <= '0;
			cyc_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (sync_edge) begin
				delay_cnt_reg <= phase_cycles;
			end else if (delay_cnt_reg != '0) begin
				delay_cnt_reg <= delay_cnt_reg - PER_W'(1);
			end
			if (start_now) begin
				cyc_cnt_reg <= '0;
			end else if (state_reg == pwm_cfg_pkg::ST_RUN) begin
				cyc_cnt_reg <= cyc_cnt_reg + PER_W'(1);
			end
		end
	end

	// On-time latched per cycle, PWM output
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			on_cycles_reg <= '0;
			pwm_out_reg <= 1'b0;
			cycle_start_reg <= 1'b0;
		end else begin
			cycle_start_reg <= start_now;
			if (start_now) begin
				on_cycles_reg <= on_scaled;
				pwm_out_reg <= on_scaled != '0;
			end else if (state_next == pwm_cfg_pkg::ST_RUN) begin
				pwm_out_reg <= (cyc_cnt_reg + PER_W'(1)) < on_cycles_reg;
			end else begin
				pwm_out_reg <= 1'b0;
			end
		end
	end

	// Helper: length of the current high pulse
	logic [PER_W:0] high_run_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			high_run_reg <= '0;
		end else begin
			high_run_reg <= pwm_out_reg ? high_run_reg + (PER_W+1)'(1) : '0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_duty_cap: assert property (pwm_out_reg |-> high_run_reg < {1'b0, limit_cycles})
		else $error("High pulse longer than duty limit");
	a_idle_quiet: assert property (!converter_enable |=> !pwm_out_reg && !cycle_start_reg)
		else $error("Switching while converter disabled");
	a_start_after_sync: assert property ((sync_edge && converter_enable)
		|-> ##[1:300] (cycle_start_reg || !converter_enable || sync_edge))
		else $error("No switch-on after sync edge");
	a_zero_slot: assert property ((sync_edge && converter_enable && phase_cycles == '0
		&& state_reg != pwm_cfg_pkg::ST_DELAY) |=> ##1 cycle_start_reg)
		else $error("Zero phase slot did not start promptly");
	a_write_blocked: assert property ((slot_loaded_reg && converter_enable)
		|=> $stable(phase_frequency_config_reg))
		else $error("Rate or phase changed while running");
	a_duty_store: assert property ((cfg.wr && cfg.sel == `REG_DUTY_SAT)
		|=> duty_saturation_config_reg == $past(cfg.data))
		else $error("Duty register write lost");
	a_over_sat: assert property ((start_now && demand.over && over_window_saturation_en)
		|=> on_cycles_reg == $past(limit_cycles))
		else $error("Over-window saturation not at limit");
	a_under_sat: assert property ((start_now && !(demand.over && over_window_saturation_en)
		&& demand.under && under_window_saturation_en) |=> on_cycles_reg == '0)
		else $error("Under-window saturation not zero");
	a_strap_load: assert property ($rose(slot_loaded_reg)
		|-> phase_slot == ($past(phase_slot_strap) ? $past(device_address) : 5'h00))
		else $error("Phase slot not loaded from strap");
	a_base_rate: assert property ((switch_rate_select == 3'h0) |=> period_reg == 8'h50)
		else $error("Rate code zero not 500 kHz period");

endmodule : pwm_phase_and_duty_config

//--- core/pwm_cfg_consts.svh
// Offsets, field positions, reset values and timing counts of the PWM configuration block
`ifndef PWM_CFG_CONSTS_SVH
`define PWM_CFG_CONSTS_SVH

// Register selects
`define REG_PHASE_FREQ 1'b0
`define REG_DUTY_SAT 1'b1

// Phase/frequency register fields
`define RATE_MSB 7
`define RATE_LSB 5
`define SLOT_MSB 4
`define SLOT_LSB 0

// Duty/saturation register fields
`define LIMIT_MSB 7
`define LIMIT_LSB 2
`define OVER_EN_BIT 1
`define UNDER_EN_BIT 0

// Reset values
`define PHASE_FREQ_RESET 8'h00
`define DUTY_SAT_RESET 8'hE8
`define SLOT_GROUNDED 5'h00

// Timing: clock rate and switching rate table in kHz
`define CLK_KHZ 40000
`define RATE_BASE_KHZ 500
`define RATE_STEP_KHZ 125
`define RATE_KHZ(code) (`RATE_BASE_KHZ + `RATE_STEP_KHZ * (code))
`define PERIOD_CYCLES(code) (`CLK_KHZ / `RATE_KHZ(code))

// Fraction shifts: 32 phase slots of 11.25 degrees, 64 duty steps
`define SLOT_SHIFT 5
`define DUTY_SHIFT 6

`endif

//--- core/pwm_cfg_pkg.sv
// Types shared by the PWM configuration block
package pwm_cfg_pkg;

	// Timing sequencer states, Gray along idle -> delay -> run
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DELAY = 2'b01,
		ST_RUN = 2'b11
	} timing_state_t;

	// Register write access from the serial interface
	typedef struct packed {
		logic wr;
		logic sel;
		logic [7:0] data;
	} reg_access_t;

	// Compensator demand with window comparator flags
	typedef struct packed {
		logic [5:0] duty;
		logic over;
		logic under;
	} demand_t;

endpackage : pwm_cfg_pkg

//--- core/frac_scale.sv
// Scales a period count by a binary fraction
`timescale 1ns/1ps
module frac_scale #(
	parameter int PER_W = 8,
	parameter int FRAC_W = 6
) (
	input wire logic [PER_W-1:0] period,
	input wire logic [FRAC_W-1:0] frac,
	output logic [PER_W-1:0] scaled
);

	logic [PER_W+FRAC_W-1:0] product;

	// Product then drop the fraction bits
	always_comb begin
		product = {{FRAC_W{1'b0}}, period} * {{PER_W{1'b0}}, frac};
		scaled = product[PER_W+FRAC_W-1:FRAC_W];
	end

endmodule : frac_scale

//--- verification/sync_master.sv
// Power manager model driving the master sync clock
`timescale 1ns/1ps
module sync_master #(
	parameter int PERIOD = 403
) (
	input wire logic clk,
	input wire logic run,
	output logic sync_line
);
	int count;

	// Start low so the line is never unknown
	initial sync_line = 1'b0;

	// One rising slope per period, held low while stopped
	always @(negedge clk) begin
		if (!run) begin
			count <= 0;
			sync_line <= 1'b0;
		end else begin
			count <= (count == PERIOD - 1) ? 0 : count + 1;
			sync_line <= (count < 4);
		end
	end
endmodule : sync_master

//--- verification/testbench.sv
// Self-checking bench for the PWM configuration block
`timescale 1ns/1ps
module testbench;
	typedef struct {
		logic [7:0] r0;
		logic [7:0] r1;
		logic [5:0] duty;
		logic over;
		logic under;
		int d;
		int p;
		int on;
	} row_t;
	// Register values, demand, then expected delay, period and on-time
	row_t rows [6] = '{
		'{8'h00, 8'hE8, 6'h20, 1'b0, 1'b0, 0, 80, 40},
		'{8'h48, 8'hE8, 6'h3F, 1'b0, 1'b0, 13, 53, 48},
		'{8'h9F, 8'h83, 6'h05, 1'b1, 1'b0, 38, 40, 20},
		'{8'h2A, 8'h41, 6'h08, 1'b0, 1'b0, 20, 64, 8},
		'{8'h7F, 8'hFE, 6'h3F, 1'b0, 1'b1, 43, 45, 44},
		'{8'h10, 8'hFD, 6'h30, 1'b1, 1'b1, 40, 80, 0}};
	logic clk;
	logic rst;
	pwm_cfg_pkg::reg_access_t cfg;
	logic rd_sel;
	logic [7:0] rd_data;
	logic sync_line;
	logic sync_run;
	logic converter_enable;
	logic strap;
	logic [4:0] addr;
	logic [5:0] duty;
	logic over;
	logic under;
	pwm_cfg_pkg::demand_t demand;
	logic pwm_out;
	logic cycle_start;
	logic [7:0] data;
	int errors;
	int total_checks;
	int cycles;
	int d;
	int p;
	int on;

	assign demand = {duty, over, under};

	pwm_phase_and_duty_config dut_u (
		.clk(clk),
		.rst(rst),
		.cfg(cfg),
		.rd_sel(rd_sel),
		.rd_data(rd_data),
		.sync_line(sync_line),
		.converter_enable(converter_enable),
		.phase_slot_strap(strap),
		.device_address(addr),
		.demand(demand),
		.pwm_out(pwm_out),
		.cycle_start(cycle_start)
	);

	sync_master master_u (
		.clk(clk),
		.run(sync_run),
		.sync_line(sync_line)
	);

	// Clock at 40 MHz
	always #12.5 clk = ~clk;

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic sel, input logic [7:0] val);
		@(negedge clk);
		cfg = '{1'b1, sel, val};
		@(negedge clk);
		cfg.wr = 1'b0;
	endtask : wr

	task automatic rd(input logic sel, output logic [7:0] val);
		@(negedge clk);
		rd_sel = sel;
		repeat (2) @(negedge clk);
		val = rd_data;
	endtask : rd

	// Edges from sync rise to start, length of one period, high cycles in it
	task automatic meas(output int dl, output int pl, output int ol);
		dl = 0;
		pl = 0;
		ol = 0;
		@(posedge sync_line);
		for (int i = 0; i < 200 && cycle_start !== 1'b1; i++) begin
			@(posedge clk);
			#1 dl++;
		end
		for (int i = 0; i < 200; i++) begin
			ol += (pwm_out === 1'b1) ? 1 : (pwm_out === 1'b0) ? 0 : 1000;
			@(posedge clk);
			#1 pl++;
			if (cycle_start === 1'b1) break;
		end
	endtask : meas

	task automatic summarize;
		if (errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize

	// Main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		cfg = '{1'b0, 1'b0, 8'h00};
		rd_sel = 1'b0;
		sync_run = 1'b1;
		converter_enable = 1'b0;
		strap = 1'b0;
		addr = 5'h1B;
		duty = 6'h00;
		over = 1'b0;
		under = 1'b0;
		repeat (2) @(negedge clk);
		check(rd_data, 8'h00);
		check(pwm_out, 1'b0);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		rd(1'b0, data);
		check(data, 8'h00);
		rd(1'b1, data);
		check(data, 8'hE8);
		foreach (rows[i]) begin
			@(negedge clk);
			converter_enable = 1'b0;
			wr(1'b0, rows[i].r0);
			wr(1'b1, rows[i].r1);
			rd(1'b0, data);
			check(data, rows[i].r0);
			rd(1'b1, data);
			check(data, rows[i].r1);
			duty = rows[i].duty;
			over = rows[i].over;
			under = rows[i].under;
			@(negedge clk);
			converter_enable = 1'b1;
			meas(d, p, on);
			check(d, rows[i].d + 2);
			check(p, rows[i].p);
			check(on, rows[i].on);
		end
		// Write to the rate and phase register while running is dropped
		wr(1'b0, 8'hFF);
		rd(1'b0, data);
		check(data, 8'h10);
		// Second reset with the strap open loads the address bits
		@(negedge clk);
		converter_enable = 1'b0;
		rst = 1'b1;
		strap = 1'b1;
		addr = 5'h15;
		repeat (2) @(negedge clk);
		check(rd_data, 8'h00);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		rd(1'b0, data);
		check(data, 8'h15);
		rd(1'b1, data);
		check(data, 8'hE8);
		summarize();
	end
endmodule : testbench
